// >>> core/pin_function_select_pkg.sv
// Package: register map, selection codes and reset values of the pin function select block
package pin_function_select_pkg;
   // Printed offsets are not multiples of four: they are register indices
   localparam logic [11:0] FUNCTION_SELECT_PINS_2_3_INDEX = 12'h1a1;
   localparam logic [11:0] FUNCTION_SELECT_PINS_4_5_INDEX = 12'h1a2;
   localparam logic [11:0] FUNCTION_SELECT_PINS_6_7_INDEX = 12'h1a3;
   localparam int unsigned ADDR_WIDTH = 14;
   localparam logic [7:0] FUNCTION_SELECT_RESET = 8'h00;
   localparam logic [31:0] READ_DATA_RESET = 32'h00000000;
   localparam int unsigned CODE_WIDTH = 4;
   localparam int unsigned PIN_COUNT = 6;
   localparam int unsigned REG_COUNT = 3;
   localparam int unsigned HIGH_NIBBLE_LSB = 4;
   localparam int unsigned LOW_NIBBLE_LSB = 0;

   typedef enum logic [3:0] {
      CODE_GPIO = 4'h0,
      CODE_INTERRUPT_0 = 4'h1,
      CODE_FRONT_END_A = 4'h4,
      CODE_FRONT_END_B = 4'h5,
      CODE_FRONT_END_C = 4'h6
   } pin_code_t;
endpackage : pin_function_select_pkg

// >>> core/pin_route_mux.sv
// One pin's function multiplexer: picks the driving source from its selection code
`timescale 1ns/100ps
module pin_route_mux (
   input wire logic [3:0] code,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   input wire logic interrupt_output_0,
   input wire logic front_end_control_a,
   input wire logic front_end_control_b,
   input wire logic front_end_control_c,
   output logic pin_out,
   output logic pin_oe,
   output logic gpio_mode
);
   always_comb begin
      pin_out = 1'b0;
      pin_oe = 1'b0;
      gpio_mode = 1'b0;
      case (code)
         pin_function_select_pkg::CODE_GPIO: begin
            pin_out = gpio_out;
            pin_oe = gpio_oe;
            gpio_mode = 1'b1;
         end
         pin_function_select_pkg::CODE_INTERRUPT_0: begin
            pin_out = interrupt_output_0;
            pin_oe = 1'b1;
         end
         pin_function_select_pkg::CODE_FRONT_END_A: begin
            pin_out = front_end_control_a;
            pin_oe = 1'b1;
         end
         pin_function_select_pkg::CODE_FRONT_END_B: begin
            pin_out = front_end_control_b;
            pin_oe = 1'b1;
         end
         pin_function_select_pkg::CODE_FRONT_END_C: begin
            pin_out = front_end_control_c;
            pin_oe = 1'b1;
         end
         default: begin
            // Reserved and prohibited codes leave the pin undriven
            pin_out = 1'b0;
            pin_oe = 1'b0;
         end
      endcase
   end
endmodule : pin_route_mux

// >>> core/pin_function_select_2_to_7.sv
// Top: APB register file and pin multiplexers for port pins 2 to 7
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module pin_function_select_2_to_7 (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pin_function_select_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic interrupt_output_0,
   input wire logic front_end_control_a,
   input wire logic front_end_control_b,
   input wire logic front_end_control_c,
   input wire logic [5:0] gpio_out,
   input wire logic [5:0] gpio_oe,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic [5:0] gpio_mode
);
   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   ////////////////////////////////////////////////////////////////////////////
   localparam int unsigned NREG = pin_function_select_pkg::REG_COUNT;
   localparam int unsigned AW = pin_function_select_pkg::ADDR_WIDTH;
   localparam logic [1:0] NO_SLOT = 2'(NREG);

   // Register index carried by a byte address
   function automatic logic [AW-3:0] word_index(input logic [AW-1:0] addr);
      return addr[AW-1:2];
   endfunction : word_index

   // Only word-aligned addresses reach a register
   function automatic logic is_aligned(input logic [AW-1:0] addr);
      return addr[1:0] == 2'b00;
   endfunction : is_aligned

   // Register slot for a byte address, or NO_SLOT when unmapped
   function automatic logic [1:0] decode_slot(input logic [AW-1:0] addr);
      logic [1:0] found;
      found = NO_SLOT;
      if (is_aligned(addr)) begin
         case (word_index(addr))
            pin_function_select_pkg::FUNCTION_SELECT_PINS_2_3_INDEX: begin
               found = 2'd0;
            end
            pin_function_select_pkg::FUNCTION_SELECT_PINS_4_5_INDEX: begin
               found = 2'd1;
            end
            pin_function_select_pkg::FUNCTION_SELECT_PINS_6_7_INDEX: begin
               found = 2'd2;
            end
            default: begin
               found = NO_SLOT;
            end
         endcase
      end
      return found;
   endfunction : decode_slot

   logic [1:0] slot;
   logic mapped;
   logic setup;
   logic access;
   logic write_access;
   logic read_setup;
   logic low_lane;

   assign slot = decode_slot(paddr);
   assign mapped = (slot != NO_SLOT);
   // First cycle of a transfer: select high, enable still low
   assign setup = psel & ~penable;
   // Access phase: the only edge at which a write may land
   assign access = psel & penable;
   assign write_access = access & pwrite;
   assign read_setup = setup & ~pwrite;
   // Only the lowest byte lane carries register bits
   assign low_lane = pstrb[0];
   // Zero-wait-state slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Function select registers
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] select_reg [NREG];
   logic [7:0] select_next [NREG];
   logic [NREG-1:0] write_hit;

   // One write strobe per register, raised only in the access phase
   for (genvar r = 0; r < NREG; r++) begin : g_hit
      assign write_hit[r] = write_access & low_lane & (slot == 2'(r));
   end

   // New byte of a register: the write data on a hit, the held value otherwise
   function automatic logic [7:0] next_byte(
      input logic [7:0] held,
      input logic [31:0] wdata,
      input logic hit);
      return hit ? wdata[7:0] : held;
   endfunction : next_byte

   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         select_next[i] = next_byte(select_reg[i], pwdata, write_hit[i]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NREG; i++) begin
            select_reg[i] <= pin_function_select_pkg::FUNCTION_SELECT_RESET;
         end
      end else begin
         for (int i = 0; i < NREG; i++) begin
            select_reg[i] <= select_next[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   // Read word of a slot, upper bytes zero; unmapped slots read as zero
   function automatic logic [31:0] read_word(
      input logic [1:0] s,
      input logic [7:0] r0,
      input logic [7:0] r1,
      input logic [7:0] r2);
      logic [31:0] word;
      word = 32'h00000000;
      case (s)
         2'd0: begin
            word = {24'h000000, r0};
         end
         2'd1: begin
            word = {24'h000000, r1};
         end
         2'd2: begin
            word = {24'h000000, r2};
         end
         default: begin
            word = 32'h00000000;
         end
      endcase
      return word;
   endfunction : read_word

   // Captured in the setup cycle, so the word stands for the whole access phase
   always_comb begin
      prdata_next = prdata_reg;
      if (read_setup) begin
         prdata_next = read_word(slot, select_reg[0], select_reg[1], select_reg[2]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= pin_function_select_pkg::READ_DATA_RESET;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin multiplexers, each on its own nibble
   ////////////////////////////////////////////////////////////////////////////
   // Selection code of one pin: even pins use the low nibble, odd pins the high one
   function automatic logic [3:0] code_of(input logic [7:0] sel, input logic odd);
      return odd ? sel[pin_function_select_pkg::HIGH_NIBBLE_LSB +: 4] :
         sel[pin_function_select_pkg::LOW_NIBBLE_LSB +: 4];
   endfunction : code_of

   logic [3:0] pin2_code;
   logic [3:0] pin3_code;
   logic [3:0] pin4_code;
   logic [3:0] pin5_code;
   logic [3:0] pin6_code;
   logic [3:0] pin7_code;
   logic [3:0] pin_code [pin_function_select_pkg::PIN_COUNT];

   assign pin2_code = code_of(select_reg[0], 1'b0);
   assign pin3_code = code_of(select_reg[0], 1'b1);
   assign pin4_code = code_of(select_reg[1], 1'b0);
   assign pin5_code = code_of(select_reg[1], 1'b1);
   assign pin6_code = code_of(select_reg[2], 1'b0);
   assign pin7_code = code_of(select_reg[2], 1'b1);

   // Pin order of the output vectors: bit 0 is pin 2
   assign pin_code[0] = pin2_code;
   assign pin_code[1] = pin3_code;
   assign pin_code[2] = pin4_code;
   assign pin_code[3] = pin5_code;
   assign pin_code[4] = pin6_code;
   assign pin_code[5] = pin7_code;

   for (genvar p = 0; p < pin_function_select_pkg::PIN_COUNT; p++) begin : g_pin
      pin_route_mux u_mux (
         .code(pin_code[p]),
         .gpio_out(gpio_out[p]),
         .gpio_oe(gpio_oe[p]),
         .interrupt_output_0(interrupt_output_0),
         .front_end_control_a(front_end_control_a),
         .front_end_control_b(front_end_control_b),
         .front_end_control_c(front_end_control_c),
         .pin_out(pin_out[p]),
         .pin_oe(pin_oe[p]),
         .gpio_mode(gpio_mode[p])
      );
   end
endmodule : pin_function_select_2_to_7

// >>> verification/pin_function_select_chk.sv
// Checker: port-level properties of the pin function select block
`timescale 1ns/100ps
module pfs_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [3:0] pstrb,
   input wire logic interrupt_output_0,
   input wire logic front_end_control_a,
   input wire logic front_end_control_c,
   input wire logic [5:0] gpio_out,
   input wire logic [5:0] gpio_oe,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] gpio_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr(a);
      psel && penable && pwrite && pstrb[0] && paddr == a;
   endsequence
   property p_wr(a, m);
      s_wr(a) |=> m == {$past(pwdata[7:4]) == 4'h0, $past(pwdata[3:0]) == 4'h0};
   endproperty
   //////////////////////////////
   a_wr_pins_23: assert property (p_wr(14'h684, gpio_mode[1:0])) else $error("pins 2 3");
   a_wr_pins_45: assert property (p_wr(14'h688, gpio_mode[3:2])) else $error("pins 4 5");
   a_wr_pins_67: assert property (p_wr(14'h68c, gpio_mode[5:4])) else $error("pins 6 7");
   a_mode_hold: assert property (!(psel && penable && pwrite) |=> $stable(gpio_mode))
      else $error("mode changed without write");
   a_gpio_pass: assert property (((pin_out ^ gpio_out) & gpio_mode) == 6'h0
      && ((pin_oe ^ gpio_oe) & gpio_mode) == 6'h0) else $error("gpio not passed");
   a_reset_mode: assert property ($rose(presetn) |-> gpio_mode == 6'h3f)
      else $error("pins not gpio after reset");
   a_err_map: assert property (psel && penable |-> pslverr == !(paddr inside
      {14'h684, 14'h688, 14'h68c}) && pready) else $error("bad error answer");
   a_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   sequence s_set(a, nib, c);
      s_wr(a) ##0 (nib == c);
   endsequence
   a_route_irq: assert property (s_set(14'h684, pwdata[3:0], 4'h1) |=>
      pin_out[0] == interrupt_output_0 && pin_oe[0]) else $error("pin 2 not on interrupt");
   a_route_fe_a: assert property (s_set(14'h684, pwdata[7:4], 4'h4) |=>
      pin_out[1] == front_end_control_a && pin_oe[1]) else $error("pin 3 not on control a");
   a_route_fe_c: assert property (s_set(14'h68c, pwdata[7:4], 4'h6) |=>
      pin_out[5] == front_end_control_c && pin_oe[5]) else $error("pin 7 not on control c");
endmodule : pfs_chk
bind pin_function_select_2_to_7 pfs_chk u_pfs_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb), .gpio_out(gpio_out),
   .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe), .gpio_mode(gpio_mode),
   .interrupt_output_0(interrupt_output_0), .front_end_control_a(front_end_control_a),
   .front_end_control_c(front_end_control_c));

// >>> verification/tb_pin_function_select_2_to_7.sv
// Testbench: register access and pin routing of the pin function select block
`timescale 1ns/100ps
module tb_pin_function_select_2_to_7;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [13:0] paddr = 14'h0, a;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf, src = 4'h0;
   logic [5:0] gpio_out = 6'h0, gpio_oe = 6'h0, pin_out, pin_oe, gpio_mode;
   logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h2, 4'hf};
   logic [15:0] v;
   logic [1:0] rg;
   logic [3:0] lo, hi;
   logic [3:0] mdl [6] = '{6{4'h0}};
   int seed = 45700, fails = 0, num_checks = 0, cyc = 0;
   initial forever #5 pclk = ~pclk;
   pin_function_select_2_to_7 u_pin_function_select_2_to_7 (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .interrupt_output_0(src[0]), .front_end_control_a(src[1]), .front_end_control_b(src[2]),
      .front_end_control_c(src[3]), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .pin_out(pin_out), .pin_oe(pin_oe), .gpio_mode(gpio_mode));
   //////////////////////////////
   function automatic logic [1:0] ex(input logic [3:0] c, input logic [15:0] s, input int i);
      case (c)
         4'h0: return {s[i], s[6+i]};
         4'h1: return {s[12], 1'b1};
         4'h4: return {s[13], 1'b1};
         4'h5: return {s[14], 1'b1};
         4'h6: return {s[15], 1'b1};
         default: return 2'b00;
      endcase
   endfunction : ex
   function automatic logic [5:0] mode_exp();
      logic [5:0] m;
      for (int p = 0; p < 6; p++) m[p] = (mdl[p] == 4'h0);
      return m;
   endfunction : mode_exp
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [13:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         print_verdict();
      end
   end
   //////////////////////////////
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         apb(1'b0, 14'h684 + 14'(4 * r), 32'h0);
         chk(rd, 32'h0);
      end
      $display("test reset done");
      for (int i = 0; i < 6; i++) for (int k = 0; k < 7; k++) begin
         a = 14'h684 + 14'(4 * (i / 2));
         apb(1'b1, a, 32'(codes[k]) << (4 * (i % 2)));
         v = 16'($random(seed));
         {src, gpio_oe, gpio_out} <= v;
         #1;
         chk(32'({pin_out[i], pin_oe[i]}), 32'(ex(codes[k], v, i)));
         chk(32'(gpio_mode[i]), 32'(codes[k] == 4'h0));
         apb(1'b0, a, 32'h0);
         chk(rd, 32'(codes[k]) << (4 * (i % 2)));
      end
      $display("test routing done");
      apb(1'b1, 14'h690, 32'hff);
      apb(1'b0, 14'h690, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      pstrb <= 4'h0;
      apb(1'b1, 14'h68c, 32'h11);
      pstrb <= 4'hf;
      apb(1'b0, 14'h68c, 32'h0);
      chk(rd, 32'hf0);
      $display("test refuse done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'(gpio_mode), 32'h3f);
      presetn <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         apb(1'b0, 14'h684 + 14'(4 * r), 32'h0);
         chk(rd, 32'h0);
      end
      $display("test mid-run reset done");
      for (int n = 0; n < 40; n++) begin
         rg = 2'($unsigned($random(seed)) % 3);
         lo = codes[$unsigned($random(seed)) % 5];
         hi = codes[$unsigned($random(seed)) % 5];
         mdl[2 * rg] = lo;
         mdl[2 * rg + 1] = hi;
         apb(1'b1, 14'h684 + 14'(4 * rg), {24'h000000, hi, lo});
         v = 16'($random(seed));
         {src, gpio_oe, gpio_out} <= v;
         #1;
         chk(32'(gpio_mode), 32'(mode_exp()));
         for (int p = 0; p < 6; p++) begin
            chk(32'({pin_out[p], pin_oe[p]}), 32'(ex(mdl[p], v, p)));
         end
         apb(1'b0, 14'h684 + 14'(4 * rg), 32'h0);
         chk(rd, {24'h000000, hi, lo});
      end
      $display("test random done");
      print_verdict();
   end
endmodule : tb_pin_function_select_2_to_7
